// file: verilog/acr_rx_recovery.v
// Asynchronous receive clock and data recovery with a 16-word output FIFO.
// Assumes sample_tick pulses at 16x (8x in double speed) the baud rate.
//
// Summary of operation
// - A falling edge on the idle-high line starts start-bit detection.
// - First low sample is 1; start validated on samples 8-10 or 4-6.
// - Two or more high validation samples reject start as noise; hunt again.
// - Valid start resynchronises sample timing, fresh for every frame.
// - Sixteen sample states per bit normally, eight in double speed.
// - Data and parity vote on samples 8-10, or 4-6 in double speed.
// - Bit is one when two or three votes high, else zero.
// - Recover bits through the first stop bit; ignore later stop bits.
// - Stop bit voted alike; zero sets the frame error flag.
// - New start edge accepted right after last stop vote sample.
// - Data plus parity bits per frame range from five to ten.
// - Each end should keep within half the total tolerance, e.g. 2.0 percent.
// - Line sampled at 16x baud normally, 8x in double speed.
`timescale 1ns/100ps
`include "acr_regs.vh"
module acr_rx_recovery #(
   parameter FIFO_DEPTH = `ACR_FIFO_DEPTH,
   parameter FIFO_AW    = 4
) (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        clk_en,
   input  wire        rx_enable,
   input  wire        sample_tick,
   input  wire        double_speed_select,
   input  wire [3:0]  frame_bits,
   input  wire        rx_line,
   output wire        rx_valid,
   input  wire        rx_ready,
   output wire [9:0]  rx_data,
   output wire        frame_error_flag,
   output reg         frame_drop_ff,
   output reg         busy_ff
);
   localparam ST_IDLE  = 2'b00;
   localparam ST_START = 2'b01;
   localparam ST_BITS  = 2'b10;

   reg [2:0] sync_ff;
   reg       line_ff;
   reg       prev_ff;
   reg [1:0] state_ff;
   reg [4:0] samp_ff;
   reg [2:0] vote_ff;
   reg [3:0] bit_idx_ff;
   reg [3:0] nbits_ff;
   reg       dbl_ff;
   reg [9:0] shift_ff;
   reg       push_ff;
   reg [10:0] push_data_ff;
   reg       nxt_line;
   wire      fifo_in_ready;
   wire [10:0] fifo_out;
   wire      vote_bit;
   wire      vote_last;
   wire [4:0] spb;
   wire [4:0] vfirst;
   wire [3:0] nbits_clamped;

   assign spb    = dbl_ff ? `ACR_SPB_DOUBLE : `ACR_SPB_NORMAL;
   assign vfirst = dbl_ff ? `ACR_VOTE_FIRST_DBL : `ACR_VOTE_FIRST_NRM;
   assign vote_bit = (vote_ff[0] & vote_ff[1]) | (vote_ff[1] & vote_ff[2]) | (vote_ff[0] & vote_ff[2]);
   // stop vote includes the sample on this tick
   assign vote_last = (vote_ff[0] & vote_ff[1]) | (vote_ff[1] & line_ff) | (vote_ff[0] & line_ff);
   assign nbits_clamped = (frame_bits < `ACR_DBITS_MIN) ? `ACR_DBITS_MIN :
                          (frame_bits > `ACR_DBITS_MAX) ? `ACR_DBITS_MAX : frame_bits;

   // pin synchroniser; change counts once stages two and three agree
   always @* begin
      nxt_line = line_ff;
      if (sync_ff[1] == sync_ff[2]) begin
         nxt_line = sync_ff[2];
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         sync_ff <= 3'h7;
         line_ff <= 1'b1;
      end else if (clk_en) begin
         sync_ff <= {sync_ff[1:0], rx_line};
         line_ff <= nxt_line;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         state_ff     <= ST_IDLE;
         prev_ff      <= 1'b1;
         samp_ff      <= 5'h00;
         vote_ff      <= 3'h0;
         bit_idx_ff   <= 4'h0;
         nbits_ff     <= `ACR_DBITS_RST;
         dbl_ff       <= 1'b0;
         shift_ff     <= 10'h000;
         push_ff      <= 1'b0;
         push_data_ff <= 11'h000;
         frame_drop_ff <= 1'b0;
         busy_ff      <= 1'b0;
      end else if (clk_en) begin
         frame_drop_ff <= 1'b0;
         if (push_ff & fifo_in_ready) begin
            push_ff <= 1'b0;
         end
         if (!rx_enable) begin
            state_ff <= ST_IDLE;
            busy_ff  <= 1'b0;
            prev_ff  <= 1'b1;
         end else if (sample_tick) begin
            prev_ff <= line_ff;
            case (state_ff)
               ST_IDLE: begin
                  if (prev_ff & ~line_ff) begin
                     samp_ff  <= 5'h01;
                     dbl_ff   <= double_speed_select;
                     nbits_ff <= nbits_clamped;
                     state_ff <= ST_START;
                     busy_ff  <= 1'b1;
                  end
               end
               ST_START: begin
                  samp_ff <= samp_ff + 5'h01;
                  if (samp_ff + 5'h01 >= vfirst && samp_ff + 5'h01 <= vfirst + 5'h02) begin
                     vote_ff <= {vote_ff[1:0], line_ff};
                  end
                  if (samp_ff == vfirst + 5'h02) begin
                     if (vote_bit) begin
                        state_ff <= ST_IDLE;
                        busy_ff  <= 1'b0;
                     end
                  end
                  // resync; bit period of spb states
                  if (samp_ff == spb) begin
                     samp_ff    <= 5'h02;
                     bit_idx_ff <= 4'h0;
                     state_ff   <= ST_BITS;
                  end
               end
               ST_BITS: begin
                  samp_ff <= (samp_ff == spb) ? 5'h01 : samp_ff + 5'h01;
                  if (samp_ff >= vfirst && samp_ff <= vfirst + 5'h02) begin
                     vote_ff <= {vote_ff[1:0], line_ff};
                  end
                  if (samp_ff == vfirst + 5'h02) begin
                     if (bit_idx_ff == nbits_ff) begin
                        // stop vote, frame error; later stops ignored
                        if (push_ff & ~fifo_in_ready) begin
                           frame_drop_ff <= 1'b1;
                        end else begin
                           push_ff      <= 1'b1;
                           push_data_ff <= {~vote_last, shift_ff >> (4'ha - nbits_ff)};
                        end
                        // hunt right after last vote sample
                        state_ff <= ST_IDLE;
                        busy_ff  <= 1'b0;
                        prev_ff  <= 1'b1;
                     end
                  end
                  if (samp_ff == spb && bit_idx_ff != nbits_ff) begin
                     shift_ff   <= {vote_bit, shift_ff[9:1]};
                     bit_idx_ff <= bit_idx_ff + 4'h1;
                  end
               end
               default: begin
                  state_ff <= ST_IDLE;
               end
            endcase
         end
      end
   end

   acr_fifo #(
      .WIDTH (11),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .clk_en    (clk_en),
      .in_valid  (push_ff),
      .in_ready  (fifo_in_ready),
      .in_data   (push_data_ff),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (fifo_out)
   );

   assign rx_data          = fifo_out[9:0];
   assign frame_error_flag = fifo_out[10];
endmodule // acr_rx_recovery

// file: pkg/acr_regs.vh
// Constants for the asynchronous receive clock and data recovery block.
// Assumes inclusion by bare name from the design files.
`ifndef ACR_REGS_VH
`define ACR_REGS_VH
`define ACR_SPB_NORMAL      5'h10
`define ACR_SPB_DOUBLE      5'h08
`define ACR_VOTE_FIRST_NRM  5'h08
`define ACR_VOTE_FIRST_DBL  5'h04
`define ACR_DBITS_MIN       4'h5
`define ACR_DBITS_MAX       4'ha
`define ACR_DBITS_RST       4'h8
`define ACR_FIFO_DEPTH      16
`define ACR_CLK_HZ          20000000
`endif

// file: verilog/acr_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock, synchronous active-low reset, clock enable.
`timescale 1ns/100ps
module acr_fifo #(
   parameter WIDTH = 11,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire             clk_en,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_ff;
   reg [AW-1:0]    rd_ptr_ff;
   reg [AW:0]      count_ff;
   wire            push;
   wire            pop;

   assign in_ready  = (count_ff != DEPTH[AW:0]);
   assign out_valid = (count_ff != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr_ff];
   assign push      = in_valid & in_ready & clk_en;
   assign pop       = out_valid & out_ready & clk_en;

   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         count_ff  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
         end
         if (push & ~pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (pop & ~push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule // acr_fifo

// file: tb/acr_rx_recovery_assertions.sv
// Port checker for the receive recovery block.
// Assumes binding to acr_rx_recovery.
`timescale 1ns/100ps
module acr_chk (
   input wire       clk,
   input wire       rst_n,
   input wire       clk_en,
   input wire       sample_tick,
   input wire       double_speed_select,
   input wire       rx_valid,
   input wire       rx_ready,
   input wire [9:0] rx_data,
   input wire       frame_error_flag,
   input wire       frame_drop_ff,
   input wire       busy_ff
);
   reg [7:0] cnt_ff;
   always @(posedge clk) cnt_ff <= (!rst_n || !busy_ff) ? 8'h00 : cnt_ff + {7'h00, sample_tick};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_tick; $past(sample_tick); endsequence
   sequence s_held; rx_valid && $stable(rx_data) && $stable(frame_error_flag); endsequence
   a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !rx_valid && !busy_ff)
      else $error("reset left state");
   a_start_on_tick: assert property ($rose(busy_ff) |-> s_tick)
      else $error("start off tick");
   a_end_on_tick: assert property ($fell(busy_ff) |-> s_tick)
      else $error("end off tick");
   a_vote_not_early: assert property ($fell(busy_ff) |-> cnt_ff >= (double_speed_select ? 8'h05 : 8'h09))
      else $error("frame ended early");
   a_frame_bound: assert property (cnt_ff <= 8'hb9)
      else $error("frame too long");
   a_word_held: assert property (rx_valid && !rx_ready && clk_en |=> s_held)
      else $error("word not held");
   a_drop_pulse: assert property (frame_drop_ff |=> !frame_drop_ff)
      else $error("drop too long");
   a_drop_full: assert property (frame_drop_ff |-> rx_valid)
      else $error("drop while empty");
   a_push_after: assert property ($rose(rx_valid) |-> !$past(busy_ff) || !$past(busy_ff, 2) || !$past(busy_ff, 3))
      else $error("word before stop");
endmodule // acr_chk
bind acr_rx_recovery acr_chk i_acr_chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .sample_tick(sample_tick),
   .double_speed_select(double_speed_select), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
   .frame_error_flag(frame_error_flag), .frame_drop_ff(frame_drop_ff), .busy_ff(busy_ff));

// file: tb/acr_tx_model.sv
// Remote serial transmitter driving the receive line.
// Assumes go pulses only while busy is low.
`timescale 1ns/100ps
module acr_tx_model (
   input wire       clk,
   input wire       go,
   input wire [7:0] bit_clks,
   input wire [7:0] stop_clks,
   input wire [3:0] nbits,
   input wire [9:0] data,
   input wire       stop_val,
   output reg       line,
   output reg       busy
);
   integer i;
   initial begin
      line = 1'b1;
      busy = 1'b0;
   end
   always @(posedge go) begin
      busy = 1'b1;
      line = 1'b0;
      repeat (nbits == 4'h0 ? stop_clks : bit_clks) @(negedge clk);
      for (i = 0; i < nbits; i = i + 1) begin
         line = data[i];
         repeat (bit_clks) @(negedge clk);
      end
      if (nbits != 4'h0) begin
         line = stop_val;
         repeat (stop_clks) @(negedge clk);
      end
      line = 1'b1;
      busy = 1'b0;
   end
endmodule // acr_tx_model

// file: tb/tb_top.sv
// Self-checking bench for the receive recovery block.
// Assumes a sample tick every second clock.
`timescale 1ns/100ps
module tb_top;
   reg         clk, rst_n, tick, dss, go, stop_val, rx_ready, hold;
   reg  [3:0]  frame_bits;
   reg  [9:0]  data;
   reg  [7:0]  stop_clks;
   wire [7:0]  bit_clks = dss ? 8'h10 : 8'h20;
   wire        line, tx_busy, rx_valid, fe, drop, busy;
   wire [9:0]  rx_data;
   reg  [10:0] exp_q[$];
   integer     err_total, compares, k;
   acr_rx_recovery i_acr_rx_recovery (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .rx_enable(1'b1),
      .sample_tick(tick), .double_speed_select(dss), .frame_bits(frame_bits), .rx_line(line),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .frame_error_flag(fe),
      .frame_drop_ff(drop), .busy_ff(busy));
   acr_tx_model i_acr_tx_model (.clk(clk), .go(go), .bit_clks(bit_clks), .stop_clks(stop_clks),
      .nbits(frame_bits), .data(data), .stop_val(stop_val), .line(line), .busy(tx_busy));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(negedge clk) tick <= ~tick;
   always @(negedge clk) rx_ready <= !hold && ($urandom % 3 != 0);
   always @(posedge clk) if (rst_n && rx_valid === 1'b1 && rx_ready === 1'b1) begin
      compares = compares + 1;
      if (exp_q.size() == 0 || {fe, rx_data} !== exp_q[0]) begin
         err_total = err_total + 1;
         $display("[ERR] %0t word mismatch", $time);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
   end
   task wrap_up;
      begin
         $display("errors %0d compares %0d", err_total, compares);
         if (err_total == 0 && compares > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task send(input d_s, input [3:0] nb, input [9:0] d, input sv);
      integer w;
      begin
         @(negedge clk);
         dss = d_s;
         frame_bits = nb;
         data = d;
         stop_val = sv;
         stop_clks = nb == 4'h0 ? 8'h06 : (d_s ? 8'h10 : 8'h1a);
         if (nb != 4'h0) exp_q.push_back({~sv, d & ((10'h001 << nb) - 10'h001)});
         go = 1'b1;
         @(negedge clk) go = 1'b0;
         w = 0;
         while (tx_busy === 1'b1 && w < 5000) begin
            @(negedge clk);
            w = w + 1;
         end
         if (nb == 4'h0 || !sv) repeat (40) @(negedge clk);
      end
   endtask
   initial begin
      {rst_n, tick, dss, go, stop_val, hold} = 6'h00;
      {frame_bits, data, stop_clks, err_total, compares} = 0;
      k = $urandom(32'h4322);
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      repeat (5) @(negedge clk);
      for (k = 0; k < 24; k = k + 1) send(k >= 16, 4'h5 + $urandom % 6, $urandom, 1'b1);
      send(1'b0, 4'h8, 10'h0a5, 1'b0);
      send(1'b0, 4'h0, 10'h000, 1'b1);
      hold = 1'b1;
      for (k = 0; k < 16; k = k + 1) send(1'b0, 4'ha, $urandom, 1'b1);
      compares = compares + 1;
      if (rx_valid !== 1'b1) begin
         err_total = err_total + 1;
         $display("[ERR] %0t buffer empty", $time);
      end
      hold = 1'b0;
      k = 0;
      while (exp_q.size() != 0 && k < 20000) begin
         @(negedge clk);
         k = k + 1;
      end
      if (exp_q.size() != 0) err_total = err_total + 1;
      wrap_up;
   end
   initial begin
      #3000000;
      err_total = err_total + 1;
      wrap_up;
   end
endmodule // tb_top
